// File: shared/tcu_pkg.sv
// Constants shared by the trap compare unit: register map, field positions,
// reset values, instruction encodings and vector offsets.
// Assumes a 32-bit core with the usual big-endian instruction field layout.
package tcu_pkg;
  // Register byte offsets on the AHB-Lite slave
  localparam logic [7:0] OFS_DBG_CTRL = 8'h00;
  localparam logic [7:0] OFS_DBG_STAT = 8'h04;
  localparam logic [7:0] OFS_MSR = 8'h08;
  localparam logic [7:0] OFS_VEC_BASE = 8'h0c;
  localparam logic [7:0] OFS_INT_PC = 8'h10;
  localparam logic [7:0] OFS_INT_ST = 8'h14;
  localparam logic [7:0] OFS_DBG_PC = 8'h18;
  localparam logic [7:0] OFS_DBG_ST = 8'h1c;
  localparam logic [7:0] OFS_SYNDROME = 8'h20;
  // Debug control fields
  localparam int CTL_TDE = 0;
  localparam int CTL_EDM = 1;
  localparam int CTL_IDM = 2;
  localparam int CTL_RESUME = 8;
  // Debug status fields
  localparam int STA_TIE = 0;
  localparam int STA_IDE = 1;
  localparam int STA_STOP = 8;
  // Machine state fields
  localparam int MSR_WE = 18;
  localparam int MSR_CE = 17;
  localparam int MSR_EE = 15;
  localparam int MSR_PR = 14;
  localparam int MSR_DE = 9;
  localparam int MSR_IR = 5;
  localparam int MSR_DR = 4;
  // Syndrome field
  localparam int SYN_PTR = 27;
  // Reset values
  localparam logic [2:0] CTL_RESET = 3'h0;
  localparam logic [31:0] MSR_RESET = 32'h0000_0000;
  localparam logic [15:0] VEC_RESET = 16'h0000;
  // Instruction encodings
  localparam logic [5:0] OP_TRAP_IMM = 6'h03;
  localparam logic [5:0] OP_EXTENDED = 6'h1f;
  localparam logic [9:0] XO_TRAP_REG = 10'h004;
  // Condition mask bit positions (value 16 is bit 4)
  localparam int TO_SLT = 4;
  localparam int TO_SGT = 3;
  localparam int TO_EQ = 2;
  localparam int TO_ULT = 1;
  localparam int TO_UGT = 0;
  // Vector offsets
  localparam logic [15:0] VEC_PROGRAM = 16'h0700;
  localparam logic [15:0] VEC_DEBUG = 16'h2000;
  typedef enum logic [2:0] {
    ACT_NONE, ACT_PROG, ACT_PROG_IMPR, ACT_DBG_INT, ACT_STOP, ACT_STOP_IMPR
  } tcu_action_t;
endpackage

// File: hw/tcu_decode.sv
// Decoder for the two trap instruction forms.
// Assumes the instruction word arrives with instruction bit 0 at bit 31.
`timescale 1ns/1ns
module tcu_decode (
  input wire logic [31:0] instr_in,
  output logic is_trap_out,
  output logic imm_form_out,
  output logic [4:0] mask_out,
  output logic [31:0] lit_out,
  output logic record_out
);
  // Field extraction; the literal is sign-extended to a full word
  always_comb begin
    imm_form_out = (instr_in[31:26] == tcu_pkg::OP_TRAP_IMM);
    is_trap_out = imm_form_out ||
      ((instr_in[31:26] == tcu_pkg::OP_EXTENDED) && (instr_in[10:1] == tcu_pkg::XO_TRAP_REG));
    mask_out = instr_in[25:21];
    lit_out = {{16{instr_in[15]}}, instr_in[15:0]};
    record_out = instr_in[0] && !imm_form_out; // Only the register form has the bit
  end
endmodule

// File: hw/tcu_compare.sv
// Five-condition comparator for the trap instructions.
// Assumes operands are stable for the cycle in which the result is used.
`timescale 1ns/1ns
module tcu_compare (
  input wire logic [4:0] mask_in,
  input wire logic [31:0] a_in,
  input wire logic [31:0] b_in,
  output logic hit_out
);
  logic slt;
  logic ult;
  logic eq;
  // Signed and unsigned views of the same two words
  always_comb begin
    slt = $signed(a_in) < $signed(b_in);
    ult = a_in < b_in;
    eq = a_in == b_in;
    // Union of every selected condition
    hit_out = (mask_in[tcu_pkg::TO_SLT] && slt) ||
      (mask_in[tcu_pkg::TO_SGT] && !slt && !eq) ||
      (mask_in[tcu_pkg::TO_EQ] && eq) ||
      (mask_in[tcu_pkg::TO_ULT] && ult) ||
      (mask_in[tcu_pkg::TO_UGT] && !ult && !eq);
  end
endmodule

// File: hw/tcu_top.sv
// Trap compare unit: evaluates trap instructions, picks the trap action from the
// debug configuration, updates save, syndrome, status and machine state registers
// and redirects the program counter. Registers sit on an AHB-Lite slave.
// Assumes the core presents one decoded slot per cycle with operand values read.
// Behaviour
// - The register form compares two operand registers and traps on any condition chosen by the five-bit mask.
// - The immediate form compares the first operand with the sign-extended 16-bit literal using the same mask.
// - Without trap debug, or with both debug modes clear, a trap is a program interrupt vectoring to prefix and 0x0700.
// - With trap debug and external debug mode set, a trap stops the core and sets the trap event flag.
// - In that stop, with internal mode set and debug exceptions off, the imprecise flag is set and the PC stays at the trap.
// - Internal mode only with debug exceptions on gives a debug interrupt vectoring to prefix and 0x2000.
// - Internal mode only with debug exceptions off sets both debug flags and takes a program interrupt.
// - A set record bit leaves the condition field zero undefined, and no other architected register changes.
// - A register trap with an all-ones mask on register zero twice always traps.
// - Mask value 16 is signed less, 8 signed greater, 4 equal, 2 unsigned less, 1 unsigned greater, ORed together.
`timescale 1ns/1ns
module tcu_top (
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  output logic [31:0] HRDATA_OUT,
  input wire logic INSTR_VALID_IN,
  input wire logic [31:0] INSTR_IN,
  input wire logic [31:0] INSTR_ADDR_IN,
  input wire logic [31:0] OPND_A_IN,
  input wire logic [31:0] OPND_B_IN,
  output logic INSTR_READY_OUT,
  output logic TRAP_TAKEN_OUT,
  output logic REDIRECT_VALID_OUT,
  output logic [31:0] REDIRECT_PC_OUT,
  output logic DEBUG_STOP_OUT,
  output logic COND_UNDEF_OUT,
  output logic [31:0] MSR_OUT
);
  logic rst_meta_reg;
  logic rst_n;
  logic is_trap;
  logic imm_form;
  logic [4:0] mask;
  logic [31:0] lit;
  logic record_bit;
  logic [31:0] second_val;
  logic hit;
  logic take;
  tcu_pkg::tcu_action_t act;
  // Architected state
  logic [2:0] ctl_reg, ctl_next;
  logic tie_reg, tie_next;
  logic ide_reg, ide_next;
  logic stop_reg, stop_next;
  logic [31:0] msr_reg, msr_next;
  logic [15:0] vec_reg, vec_next;
  logic [31:0] ipc_reg, ipc_next;
  logic [31:0] ist_reg, ist_next;
  logic [31:0] dpc_reg, dpc_next;
  logic [31:0] dst_reg, dst_next;
  logic ptr_reg, ptr_next;
  // Core-facing result
  logic trap_reg, trap_next;
  logic redir_reg, redir_next;
  logic [31:0] rpc_reg, rpc_next;
  logic undef_reg, undef_next;
  // Bus slave state
  logic wr_pend_reg, wr_pend_next;
  logic rd_pend_reg, rd_pend_next;
  logic [7:0] addr_reg, addr_next;
  logic [31:0] rdata_reg, rdata_next;
  logic addr_phase;
  logic [31:0] rd_mux;
  logic [31:0] msr_cleared;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  tcu_decode u_decode (
    .instr_in(INSTR_IN),
    .is_trap_out(is_trap),
    .imm_form_out(imm_form),
    .mask_out(mask),
    .lit_out(lit),
    .record_out(record_bit)
  );

  // Literal replaces the second register for the immediate form
  assign second_val = imm_form ? lit : OPND_B_IN;

  tcu_compare u_compare (
    .mask_in(mask),
    .a_in(OPND_A_IN),
    .b_in(second_val),
    .hit_out(hit)
  );

  // No new instruction is accepted while the core sits in debug stop
  assign INSTR_READY_OUT = !stop_reg;
  // An all-ones mask with equal register-zero operands hits through the equal term
  assign take = INSTR_VALID_IN && !stop_reg && is_trap && hit;

  // Action select from the debug configuration and debug exception enable
  always_comb begin
    act = tcu_pkg::ACT_NONE;
    if (take) begin
      if (!ctl_reg[tcu_pkg::CTL_TDE] ||
          (!ctl_reg[tcu_pkg::CTL_EDM] && !ctl_reg[tcu_pkg::CTL_IDM])) begin
        act = tcu_pkg::ACT_PROG;
      end else if (ctl_reg[tcu_pkg::CTL_EDM]) begin
        if (ctl_reg[tcu_pkg::CTL_IDM] && !msr_reg[tcu_pkg::MSR_DE]) begin
          act = tcu_pkg::ACT_STOP_IMPR;
        end else begin
          act = tcu_pkg::ACT_STOP;
        end
      end else if (msr_reg[tcu_pkg::MSR_DE]) begin
        act = tcu_pkg::ACT_DBG_INT;
      end else begin
        act = tcu_pkg::ACT_PROG_IMPR;
      end
    end
  end

  // Machine state with the program-interrupt bits cleared
  always_comb begin
    msr_cleared = msr_reg;
    msr_cleared[tcu_pkg::MSR_WE] = 1'b0;
    msr_cleared[tcu_pkg::MSR_EE] = 1'b0;
    msr_cleared[tcu_pkg::MSR_PR] = 1'b0;
    msr_cleared[tcu_pkg::MSR_DR] = 1'b0;
    msr_cleared[tcu_pkg::MSR_IR] = 1'b0;
  end

  // Bus address phase taken only when the bus is ready and a transfer is live
  assign addr_phase = HSEL_IN && HTRANS_IN[1] && HREADY_IN;

  // Read mux over all mapped registers; unmapped words read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (addr_reg)
      tcu_pkg::OFS_DBG_CTRL: rd_mux[2:0] = ctl_reg;
      tcu_pkg::OFS_DBG_STAT: begin
        rd_mux[tcu_pkg::STA_TIE] = tie_reg;
        rd_mux[tcu_pkg::STA_IDE] = ide_reg;
        rd_mux[tcu_pkg::STA_STOP] = stop_reg;
      end
      tcu_pkg::OFS_MSR: rd_mux = msr_reg;
      tcu_pkg::OFS_VEC_BASE: rd_mux[31:16] = vec_reg;
      tcu_pkg::OFS_INT_PC: rd_mux = ipc_reg;
      tcu_pkg::OFS_INT_ST: rd_mux = ist_reg;
      tcu_pkg::OFS_DBG_PC: rd_mux = dpc_reg;
      tcu_pkg::OFS_DBG_ST: rd_mux = dst_reg;
      tcu_pkg::OFS_SYNDROME: rd_mux[tcu_pkg::SYN_PTR] = ptr_reg;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Bus slave sequencing: writes take no wait, reads take one wait state so
  // that a write just before a read is always seen by it
  always_comb begin
    wr_pend_next = 1'b0;
    rd_pend_next = 1'b0;
    addr_next = addr_reg;
    rdata_next = rdata_reg;
    if (rd_pend_reg) begin
      rdata_next = rd_mux;
    end else if (addr_phase) begin
      addr_next = {HADDR_IN[7:2], 2'b00};
      wr_pend_next = HWRITE_IN;
      rd_pend_next = !HWRITE_IN;
    end
  end

  assign HREADYOUT_OUT = !rd_pend_reg;
  assign HRESP_OUT = 1'b0;
  assign HRDATA_OUT = rdata_reg;

  // Architected register updates; a trap in the same cycle as a bus write wins
  always_comb begin
    ctl_next = ctl_reg;
    tie_next = tie_reg;
    ide_next = ide_reg;
    stop_next = stop_reg;
    msr_next = msr_reg;
    vec_next = vec_reg;
    ipc_next = ipc_reg;
    ist_next = ist_reg;
    dpc_next = dpc_reg;
    dst_next = dst_reg;
    ptr_next = ptr_reg;
    if (wr_pend_reg) begin
      unique case (addr_reg)
        tcu_pkg::OFS_DBG_CTRL: begin
          ctl_next = HWDATA_IN[2:0];
          if (HWDATA_IN[tcu_pkg::CTL_RESUME]) begin
            stop_next = 1'b0;
          end
        end
        tcu_pkg::OFS_DBG_STAT: begin
          // Write one to clear; a same-cycle trap sets again below
          if (HWDATA_IN[tcu_pkg::STA_TIE]) begin
            tie_next = 1'b0;
          end
          if (HWDATA_IN[tcu_pkg::STA_IDE]) begin
            ide_next = 1'b0;
          end
        end
        tcu_pkg::OFS_MSR: msr_next = HWDATA_IN;
        tcu_pkg::OFS_VEC_BASE: vec_next = HWDATA_IN[31:16];
        tcu_pkg::OFS_INT_PC: ipc_next = HWDATA_IN;
        tcu_pkg::OFS_INT_ST: ist_next = HWDATA_IN;
        tcu_pkg::OFS_DBG_PC: dpc_next = HWDATA_IN;
        tcu_pkg::OFS_DBG_ST: dst_next = HWDATA_IN;
        tcu_pkg::OFS_SYNDROME: ptr_next = HWDATA_IN[tcu_pkg::SYN_PTR];
        default: ;
      endcase
    end
    unique case (act)
      tcu_pkg::ACT_PROG, tcu_pkg::ACT_PROG_IMPR: begin
        ipc_next = INSTR_ADDR_IN;
        ist_next = msr_reg;
        ptr_next = 1'b1;
        msr_next = msr_cleared;
        if (act == tcu_pkg::ACT_PROG_IMPR) begin
          tie_next = 1'b1;
          ide_next = 1'b1;
        end
      end
      tcu_pkg::ACT_DBG_INT: begin
        dpc_next = INSTR_ADDR_IN;
        dst_next = msr_reg;
        tie_next = 1'b1;
        msr_next = msr_cleared;
        msr_next[tcu_pkg::MSR_CE] = 1'b0;
        msr_next[tcu_pkg::MSR_DE] = 1'b0;
      end
      tcu_pkg::ACT_STOP, tcu_pkg::ACT_STOP_IMPR: begin
        stop_next = 1'b1;
        tie_next = 1'b1;
        if (act == tcu_pkg::ACT_STOP_IMPR) begin
          ide_next = 1'b1;
        end
      end
      tcu_pkg::ACT_NONE: ;
    endcase
  end

  // Core-facing result, one cycle after the trap slot so the core can squash
  // younger instructions before any of them commits
  always_comb begin
    trap_next = take;
    redir_next = 1'b0;
    rpc_next = rpc_reg;
    undef_next = INSTR_VALID_IN && !stop_reg && is_trap && record_bit;
    unique case (act)
      tcu_pkg::ACT_PROG, tcu_pkg::ACT_PROG_IMPR: begin
        redir_next = 1'b1;
        rpc_next = {vec_reg, tcu_pkg::VEC_PROGRAM};
      end
      tcu_pkg::ACT_DBG_INT: begin
        redir_next = 1'b1;
        rpc_next = {vec_reg, tcu_pkg::VEC_DEBUG};
      end
      tcu_pkg::ACT_STOP_IMPR: begin
        redir_next = 1'b1;
        rpc_next = INSTR_ADDR_IN;
      end
      tcu_pkg::ACT_STOP, tcu_pkg::ACT_NONE: ;
    endcase
  end

  assign TRAP_TAKEN_OUT = trap_reg;
  assign REDIRECT_VALID_OUT = redir_reg;
  assign REDIRECT_PC_OUT = rpc_reg;
  assign DEBUG_STOP_OUT = stop_reg;
  assign COND_UNDEF_OUT = undef_reg;
  // Of the architected state only the machine state and the stop flag leave the unit; no general register is written
  assign MSR_OUT = msr_reg;

  // All state registered on the synchronised reset
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      ctl_reg <= tcu_pkg::CTL_RESET;
      tie_reg <= 1'b0;
      ide_reg <= 1'b0;
      stop_reg <= 1'b0;
      msr_reg <= tcu_pkg::MSR_RESET;
      vec_reg <= tcu_pkg::VEC_RESET;
      ipc_reg <= 32'h0000_0000;
      ist_reg <= 32'h0000_0000;
      dpc_reg <= 32'h0000_0000;
      dst_reg <= 32'h0000_0000;
      ptr_reg <= 1'b0;
      trap_reg <= 1'b0;
      redir_reg <= 1'b0;
      rpc_reg <= 32'h0000_0000;
      undef_reg <= 1'b0;
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ctl_reg <= ctl_next;
      tie_reg <= tie_next;
      ide_reg <= ide_next;
      stop_reg <= stop_next;
      msr_reg <= msr_next;
      vec_reg <= vec_next;
      ipc_reg <= ipc_next;
      ist_reg <= ist_next;
      dpc_reg <= dpc_next;
      dst_reg <= dst_next;
      ptr_reg <= ptr_next;
      trap_reg <= trap_next;
      redir_reg <= redir_next;
      rpc_reg <= rpc_next;
      undef_reg <= undef_next;
      wr_pend_reg <= wr_pend_next;
      rd_pend_reg <= rd_pend_next;
      addr_reg <= addr_next;
      rdata_reg <= rdata_next;
    end
  end
endmodule

// File: test/tcu_assertions.sv
// Checker for the trap compare unit: timing relations on the instruction slot side.
// Assumes it is bound to the top module and sees only that module's ports.
`timescale 1ns/1ns
module tcu_checker (
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic INSTR_VALID_IN,
  input wire logic [31:0] INSTR_IN,
  input wire logic [31:0] OPND_A_IN,
  input wire logic [31:0] OPND_B_IN,
  input wire logic INSTR_READY_OUT,
  input wire logic TRAP_TAKEN_OUT,
  input wire logic REDIRECT_VALID_OUT,
  input wire logic [31:0] REDIRECT_PC_OUT,
  input wire logic DEBUG_STOP_OUT,
  input wire logic COND_UNDEF_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  // Decoded slot qualifiers, so each property names its cause plainly
  logic acc;
  logic reg_form;
  assign acc = INSTR_VALID_IN && INSTR_READY_OUT;
  assign reg_form = INSTR_IN[31:26] == 6'h1f && INSTR_IN[10:1] == 10'h004;
  // Redirects outside a stop go only to the two interrupt vectors
  redirect_vec_a: assert property (REDIRECT_VALID_OUT && !DEBUG_STOP_OUT |->
    REDIRECT_PC_OUT[15:0] inside {16'h0700, 16'h2000}) else $error("bad vector");
  // Once stopped, slots are refused: a leak here would let a trap fire twice
  stop_hold_a: assert property (DEBUG_STOP_OUT && $past(DEBUG_STOP_OUT) |->
    !INSTR_READY_OUT && !TRAP_TAKEN_OUT && !REDIRECT_VALID_OUT)
    else $error("slot taken while stopped");
  stop_entry_a: assert property ($rose(DEBUG_STOP_OUT) |-> TRAP_TAKEN_OUT)
    else $error("stop without trap");
  taken_cause_a: assert property (TRAP_TAKEN_OUT |-> $past(acc))
    else $error("trap without slot");
  taken_opcode_a: assert property (TRAP_TAKEN_OUT |->
    $past(INSTR_IN[31:26]) inside {6'h03, 6'h1f}) else $error("trap from other opcode");
  uncond_trap_a: assert property (acc && reg_form && INSTR_IN[25:21] == 5'h1f |=>
    TRAP_TAKEN_OUT) else $error("all ones mask missed");
  equal_trap_a: assert property (acc && reg_form && INSTR_IN[23] &&
    OPND_A_IN == OPND_B_IN |=> TRAP_TAKEN_OUT) else $error("equal missed");
  imm_literal_a: assert property (acc && INSTR_IN[31:26] == 6'h03 &&
    INSTR_IN[25:21] == 5'h04 |=>
    TRAP_TAKEN_OUT == $past(OPND_A_IN == {{16{INSTR_IN[15]}}, INSTR_IN[15:0]}))
    else $error("literal compare wrong");
  undef_flag_a: assert property (acc && reg_form && INSTR_IN[0] |=> COND_UNDEF_OUT)
    else $error("record flag missed");
endmodule
bind tcu_top tcu_checker chk_u (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN),
  .INSTR_VALID_IN(INSTR_VALID_IN), .INSTR_IN(INSTR_IN), .OPND_A_IN(OPND_A_IN),
  .OPND_B_IN(OPND_B_IN), .INSTR_READY_OUT(INSTR_READY_OUT), .TRAP_TAKEN_OUT(TRAP_TAKEN_OUT),
  .REDIRECT_VALID_OUT(REDIRECT_VALID_OUT), .REDIRECT_PC_OUT(REDIRECT_PC_OUT),
  .DEBUG_STOP_OUT(DEBUG_STOP_OUT), .COND_UNDEF_OUT(COND_UNDEF_OUT));

// File: test/tcu_tb.sv
// Self-checking bench for the trap compare unit: bus tasks, slot task, scenarios.
// Assumes one AHB-Lite slave, so the bus ready is the slave's own ready.
`timescale 1ns/1ns
module tb;
  logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b1, hwrite = 1'b0, ivalid = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, instr = 32'h0, iaddr = 32'h100;
  logic [31:0] opa = 32'h0, opb = 32'h0, hrdata, rpc, mstate, rd, s_pc, s_mst;
  logic hready, hresp, irdy, ttk, rvld, dstop, cund;
  logic [4:0] snap;
  int n_mismatch = 0;
  int total_checks = 0;
  localparam logic [31:0] VB = 32'habcd_0000;
  localparam logic [31:0] ALL = 32'hffff_ffff;
  localparam logic [31:0] PCLR = ~(32'h1 << tcu_pkg::MSR_WE | 32'h1 << tcu_pkg::MSR_EE |
    32'h1 << tcu_pkg::MSR_PR | 32'h1 << tcu_pkg::MSR_DR | 32'h1 << tcu_pkg::MSR_IR);
  localparam logic [31:0] DCLR = PCLR & ~(32'h1 << tcu_pkg::MSR_CE | 32'h1 << tcu_pkg::MSR_DE);
  always #10 clk = ~clk;
  tcu_top dut_u (.CLK_IN(clk), .RST_N_IN(rst_n), .HSEL_IN(hsel), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
    .HREADY_IN(hready), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp), .HRDATA_OUT(hrdata),
    .INSTR_VALID_IN(ivalid), .INSTR_IN(instr), .INSTR_ADDR_IN(iaddr), .OPND_A_IN(opa),
    .OPND_B_IN(opb), .INSTR_READY_OUT(irdy), .TRAP_TAKEN_OUT(ttk), .REDIRECT_VALID_OUT(rvld),
    .REDIRECT_PC_OUT(rpc), .DEBUG_STOP_OUT(dstop), .COND_UNDEF_OUT(cund), .MSR_OUT(mstate));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Ready is sampled at the falling edge before the edge that completes the phase
  task automatic wait_rdy();
    int n;
    logic r;
    n = 0;
    do begin
      @(negedge clk);
      r = hready;
      rd = hrdata;
      @(posedge clk);
      n++;
    end while (r !== 1'b1 && n < 40);
    if (r !== 1'b1) begin
      n_mismatch++;
      end_of_test();
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask
  // One slot; outputs are caught in the cycle after the slot edge
  task automatic slot(input logic [31:0] ins, input logic [31:0] a, input logic [31:0] b);
    ivalid <= 1'b1;
    instr <= ins;
    iaddr <= iaddr + 32'h4;
    opa <= a;
    opb <= b;
    @(posedge clk);
    ivalid <= 1'b0;
    @(negedge clk);
    snap = {ttk, rvld, dstop, cund, irdy};
    s_pc = rpc;
    s_mst = mstate;
    @(posedge clk);
  endtask
  function automatic logic [31:0] enc_reg(input logic [4:0] m, input logic rec);
    return {tcu_pkg::OP_EXTENDED, m, 5'h1, 5'h2, tcu_pkg::XO_TRAP_REG, rec};
  endfunction
  function automatic logic [31:0] enc_imm(input logic [4:0] m, input logic [15:0] lit);
    return {tcu_pkg::OP_TRAP_IMM, m, 5'h1, lit};
  endfunction
  // Mask bit 4 signed less, 3 signed greater, 2 equal, 1 unsigned less, 0 unsigned greater
  function automatic logic hit(input logic [4:0] m, input logic [31:0] a, input logic [31:0] b);
    return (m[4] && $signed(a) < $signed(b)) || (m[3] && $signed(a) > $signed(b)) ||
      (m[2] && a == b) || (m[1] && a < b) || (m[0] && a > b);
  endfunction
  task automatic t_program();
    bus(1'b1, tcu_pkg::OFS_VEC_BASE, VB);
    bus(1'b1, tcu_pkg::OFS_MSR, ALL);
    slot({tcu_pkg::OP_EXTENDED, 5'h1f, 10'h0, tcu_pkg::XO_TRAP_REG, 1'b0}, 32'h0, 32'h0);
    check("prog flags", {27'h0, snap}, 32'h19);
    check("prog pc", s_pc, {VB[31:16], tcu_pkg::VEC_PROGRAM});
    check("prog state", s_mst, PCLR);
    rd_chk("save pc", tcu_pkg::OFS_INT_PC, iaddr);
    check("bus resp", {31'h0, hresp}, 32'h0);
    rd_chk("save state", tcu_pkg::OFS_INT_ST, ALL);
    rd_chk("cause", tcu_pkg::OFS_SYNDROME, 32'h1 << tcu_pkg::SYN_PTR);
    rd_chk("status", tcu_pkg::OFS_DBG_STAT, 32'h0);
    rd_chk("dbg save", tcu_pkg::OFS_DBG_PC, 32'h0);
    rd_chk("unmapped", 8'h3c, 32'h0);
  endtask
  // Every single-condition mask against signed and unsigned edge pairs, both forms
  task automatic t_table();
    logic [31:0] pa [3];
    logic [31:0] pb [3];
    logic [4:0] m;
    pa = '{ALL, 32'h1, 32'h5};
    pb = '{32'h1, ALL, 32'h5};
    for (int f = 0; f < 2; f++) begin
      for (int k = 0; k < 5; k++) begin
        for (int p = 0; p < 3; p++) begin
          m = 5'h1 << k;
          if (f == 0) begin
            slot(enc_reg(m, p[0]), pa[p], pb[p]);
          end else begin
            slot(enc_imm(m, pb[p][15:0]), pa[p], 32'h0);
          end
          check("decision", {30'h0, snap[4], snap[1]},
            {30'h0, hit(m, pa[p], pb[p]), f == 0 && p[0]});
        end
      end
    end
  endtask
  task automatic t_debug();
    bus(1'b1, tcu_pkg::OFS_DBG_CTRL, 32'h5);
    bus(1'b1, tcu_pkg::OFS_MSR, ALL);
    slot(enc_reg(5'h04, 1'b0), 32'h7, 32'h7);
    check("dbg flags", {27'h0, snap}, 32'h19);
    check("dbg pc", s_pc, {VB[31:16], tcu_pkg::VEC_DEBUG});
    check("dbg state", s_mst, DCLR);
    rd_chk("dbg save pc", tcu_pkg::OFS_DBG_PC, iaddr);
    rd_chk("dbg save state", tcu_pkg::OFS_DBG_ST, ALL);
    rd_chk("dbg status", tcu_pkg::OFS_DBG_STAT, 32'h1);
    bus(1'b1, tcu_pkg::OFS_DBG_STAT, 32'h3);
    // Debug exceptions are now off, so the same trap turns imprecise
    slot(enc_reg(5'h04, 1'b0), 32'h7, 32'h7);
    check("impr pc", s_pc, {VB[31:16], tcu_pkg::VEC_PROGRAM});
    rd_chk("impr save", tcu_pkg::OFS_INT_ST, DCLR);
    rd_chk("impr status", tcu_pkg::OFS_DBG_STAT, 32'h3);
    bus(1'b1, tcu_pkg::OFS_DBG_STAT, 32'h3);
  endtask
  task automatic t_stop();
    bus(1'b1, tcu_pkg::OFS_DBG_CTRL, 32'h3);
    slot(enc_reg(5'h04, 1'b0), 32'h1, 32'h1);
    check("stop flags", {27'h0, snap}, 32'h14);
    rd_chk("stop status", tcu_pkg::OFS_DBG_STAT, 32'h101);
    slot(enc_reg(5'h04, 1'b0), 32'h1, 32'h1);
    check("stopped slot", {27'h0, snap}, 32'h04);
    bus(1'b1, tcu_pkg::OFS_DBG_CTRL, 32'h107);
    bus(1'b1, tcu_pkg::OFS_DBG_STAT, 32'h3);
    bus(1'b1, tcu_pkg::OFS_MSR, 32'h0);
    slot(enc_reg(5'h04, 1'b0), 32'h1, 32'h1);
    check("impr stop flags", {27'h0, snap}, 32'h1c);
    check("impr stop pc", s_pc, iaddr);
    check("impr stop state", s_mst, 32'h0);
    rd_chk("impr stop status", tcu_pkg::OFS_DBG_STAT, 32'h103);
    bus(1'b1, tcu_pkg::OFS_DBG_CTRL, 32'h100);
    rd_chk("resumed", tcu_pkg::OFS_DBG_STAT, 32'h3);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_program();
    t_table();
    t_debug();
    t_stop();
    end_of_test();
  end
endmodule
